// ### logic/can_filt_pkg.sv
// constants shared by the filter routing block: offsets, field layout, resets
// assumes a 32-bit axi4-lite register bus
package can_filt_pkg;
	localparam int unsigned addr_w = 8;
	localparam int unsigned num_filters = 8;
	localparam int unsigned num_masks = 4;
	localparam int unsigned num_fifos = 16;
	localparam int unsigned id_w = 29;
	localparam int unsigned dest_w = 5;
	localparam int unsigned pick_w = 2;
	// register byte addresses
	localparam logic [addr_w-1:0] filter_ctrl_word_0_off = 8'h00;
	localparam logic [addr_w-1:0] filter_ctrl_word_1_off = 8'h04;
	localparam logic [addr_w-1:0] mask_0_off = 8'h10;
	localparam logic [addr_w-1:0] filter_id_0_off = 8'h20;
	localparam logic [addr_w-1:0] mode_off = 8'h40;
	localparam logic [addr_w-1:0] hit_status_off = 8'h44;
	// per-byte filter field layout
	localparam int unsigned enable_bit = 7;
	localparam int unsigned pick_lsb = 5;
	localparam int unsigned dest_lsb = 0;
	localparam int unsigned filters_per_word = 4;
	// reset values, configuration mode code and response codes
	localparam logic [31:0] ctrl_word_reset = 32'h00000000;
	localparam logic [id_w-1:0] mask_reset = 29'h00000000;
	localparam logic [2:0] mode_reset = 3'h4;
	localparam logic [2:0] mode_config = 3'h4;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	typedef struct packed {
		logic enable;
		logic [pick_w-1:0] mask_pick;
		logic [dest_w-1:0] fifo_dest;
	} filter_cfg_t;
endpackage

// ### logic/filter_cfg_if.sv
// carries one filter's settings and match result between the modules
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface filter_cfg_if;
	import can_filt_pkg::*;
	filter_cfg_t cfg;
	logic [id_w-1:0] mask;
	logic [id_w-1:0] ident;
	logic hit;
	modport ctrl (output cfg, output mask, output ident, input hit);
	modport unit (input cfg, input mask, input ident, output hit);
endinterface

// ### logic/filter_match.sv
// one acceptance filter comparison against a received identifier
// assumes mask already chosen by the caller from the filter's pick field
`timescale 1ns/1ps
module filter_match
	import can_filt_pkg::*;
(
	// received identifier
	input wire logic [can_filt_pkg::id_w-1:0] rx_id,
	// settings and result
	filter_cfg_if.unit cfg_port
);
	// masked compare; disabled filters never hit
	assign cfg_port.hit = cfg_port.cfg.enable &&
		(((rx_id ^ cfg_port.ident) & cfg_port.mask) == '0);
endmodule

// ### logic/can_filter_route_control.sv
// filter control words, masks and routing of accepted frames to fifos
// assumes axi4-lite master on aclk; rx_id/rx_valid come from the same clock
//
// Overview of operation
// - enable bit includes or excludes each filter
// - two-bit pick chooses acceptance mask 0-3
// - destination 0-15 routes accepted frame to fifo
// - filter 0 in word 0 bits 7:0
// - filter 1 in word 0 bits 15:8
// - filter 2 in word 0 bits 23:16
// - filter 3 in word 0 bits 31:24
// - mask one compares bit, zero ignores it
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module can_filter_route_control
	import can_filt_pkg::*;
(
	// clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// axi4-lite write address
	input wire logic [can_filt_pkg::addr_w-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [can_filt_pkg::addr_w-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// received frame from the bit engine
	input wire logic [can_filt_pkg::id_w-1:0] rx_id,
	input wire logic rx_valid,
	// write strobe toward the receive fifos
	output logic fifo_wr,
	output logic [3:0] fifo_sel,
	output logic [can_filt_pkg::id_w-1:0] fifo_id
);
	import can_filt_pkg::*;

	// elaboration check: the field layout serves two words of four filters
	if (num_filters != 2 * filters_per_word) begin : g_bad_count
		$error("filter count must match two control words");
	end

	// register storage; masks and identifiers are 29 bits wide
	logic [31:0] ctrl_word [2];
	logic [id_w-1:0] mask [num_masks];
	logic [id_w-1:0] ident [num_filters];
	logic [2:0] mode;
	logic [num_filters-1:0] hits;
	logic [num_filters-1:0] last_hits;
	logic have_aw, have_w;
	logic [addr_w-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	filter_cfg_if fif [num_filters] ();

	// one comparator per filter, fields sliced from the control words
	genvar g;
	generate
		for (g = 0; g < num_filters; g++) begin : g_filt
			localparam int w = g / filters_per_word;
			localparam int b = (g % filters_per_word) * 8;
			assign fif[g].cfg.enable = ctrl_word[w][b+enable_bit];
			assign fif[g].cfg.mask_pick =
				ctrl_word[w][b+pick_lsb +: pick_w];
			assign fif[g].cfg.fifo_dest =
				ctrl_word[w][b+dest_lsb +: dest_w];
			assign fif[g].mask = mask[fif[g].cfg.mask_pick];
			assign fif[g].ident = ident[g];
			assign hits[g] = fif[g].hit;
			filter_match u_match (
				.rx_id(rx_id),
				.cfg_port(fif[g])
			);
		end
	endgenerate

	// byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction

	// write channel: address and data taken in either order
	// readies drop with clk_en so no half is taken while state is frozen
	// limitation: a response handshake during a freeze is not seen
	assign s_axi_awready = clk_en && !have_aw && !s_axi_bvalid;
	assign s_axi_wready = clk_en && !have_w && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (have_aw && have_w) begin
				have_aw <= 1'b0;
				have_w <= 1'b0;
			end
		end
	end

	logic do_wr;
	logic wr_ok;
	logic [addr_w-1:0] wa;
	assign do_wr = have_aw && have_w;
	assign wa = {aw_addr[addr_w-1:2], 2'b00};

	// merged words for the 29-bit registers; top bits dropped on store
	logic [31:0] mask_merged;
	logic [31:0] ident_merged;
	assign mask_merged = merge({3'h0, mask[wa[3:2]]}, w_data, w_strb);
	assign ident_merged = merge({3'h0, ident[wa[4:2]]}, w_data, w_strb);

	// decode: which addresses accept a write
	always_comb begin
		wr_ok = 1'b0;
		if (wa == filter_ctrl_word_0_off || wa == filter_ctrl_word_1_off ||
				wa == mode_off)
			wr_ok = 1'b1;
		else if (wa >= mask_0_off && wa < mask_0_off + 8'h10)
			wr_ok = (mode == mode_config);
		else if (wa >= filter_id_0_off && wa < filter_id_0_off + 8'h20)
			wr_ok = 1'b1;
	end

	// control words, reset to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_word[0] <= ctrl_word_reset;
			ctrl_word[1] <= ctrl_word_reset;
		end else if (clk_en && do_wr) begin
			// reserved destinations stored as written; software keeps clear
			if (wa == filter_ctrl_word_0_off)
				ctrl_word[0] <= merge(ctrl_word[0], w_data, w_strb);
			if (wa == filter_ctrl_word_1_off)
				ctrl_word[1] <= merge(ctrl_word[1], w_data, w_strb);
		end
	end

	// acceptance masks, writable only in configuration mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < num_masks; i++)
				mask[i] <= mask_reset;
		end else if (clk_en && do_wr && wr_ok &&
				wa[7:4] == mask_0_off[7:4]) begin
			mask[wa[3:2]] <= mask_merged[id_w-1:0];
		end
	end

	// filter identifiers and operating mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < num_filters; i++)
				ident[i] <= '0;
			mode <= mode_reset;
		end else if (clk_en && do_wr) begin
			if (wa[7:5] == filter_id_0_off[7:5])
				ident[wa[4:2]] <= ident_merged[id_w-1:0];
			if (wa == mode_off && w_strb[0])
				mode <= w_data[2:0];
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else if (clk_en) begin
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? resp_okay : resp_slverr;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read path: one read in flight, answered the cycle after arvalid
	// unmapped reads answer slverr with zero data
	assign s_axi_arready = clk_en && !s_axi_rvalid;
	logic [addr_w-1:0] ra;
	assign ra = {s_axi_araddr[addr_w-1:2], 2'b00};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= resp_okay;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= resp_okay;
				if (ra == filter_ctrl_word_0_off)
					s_axi_rdata <= ctrl_word[0];
				else if (ra == filter_ctrl_word_1_off)
					s_axi_rdata <= ctrl_word[1];
				else if (ra[7:4] == mask_0_off[7:4])
					s_axi_rdata <= {3'h0, mask[ra[3:2]]};
				else if (ra[7:5] == filter_id_0_off[7:5])
					s_axi_rdata <= {3'h0, ident[ra[4:2]]};
				else if (ra == mode_off)
					s_axi_rdata <= {29'h0, mode};
				else if (ra == hit_status_off)
					s_axi_rdata <= {24'h0, last_hits};
				else begin
					s_axi_rdata <= '0;
					s_axi_rresp <= resp_slverr;
				end
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// destination fields gathered so the priority loop can index them
	logic [dest_w-1:0] dests [num_filters];
	generate
		for (g = 0; g < num_filters; g++) begin : g_dest
			assign dests[g] = fif[g].cfg.fifo_dest;
		end
	endgenerate

	// routing: lowest-numbered hitting filter wins; no frames in config mode
	// reserved codes keep only their low four bits here
	logic any_hit;
	logic [3:0] win_dest;
	always_comb begin
		any_hit = 1'b0;
		win_dest = '0;
		for (int i = int'(num_filters) - 1; i >= 0; i--) begin
			if (hits[i]) begin
				any_hit = 1'b1;
				win_dest = dests[i][3:0];
			end
		end
	end

	// fifo write strobe, one cycle per accepted frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifo_wr <= 1'b0;
			fifo_sel <= '0;
			fifo_id <= '0;
			last_hits <= '0;
		end else if (clk_en) begin
			fifo_wr <= rx_valid && any_hit && mode != mode_config;
			if (rx_valid) begin
				fifo_sel <= win_dest;
				fifo_id <= rx_id;
				last_hits <= hits;
			end
		end
	end
endmodule

// ### verif/can_filt_assertions.sv
// checker for the filter routing block's ports
// assumes a single clock; readies stay low while clk_en is low
`timescale 1ns/1ps
module can_filt_checker
	import can_filt_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// frame path
	input wire logic [can_filt_pkg::id_w-1:0] rx_id,
	input wire logic rx_valid,
	input wire logic fifo_wr,
	input wire logic [3:0] fifo_sel,
	input wire logic [can_filt_pkg::id_w-1:0] fifo_id
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// a strobe needs a frame one edge earlier
	AST_WR_CAUSE: assert property (
		fifo_wr |-> $past(rx_valid))
		else $error("fifo write without frame");
	AST_ID_ECHO: assert property (
		fifo_wr |-> fifo_id == $past(rx_id))
		else $error("fifo id differs from frame");
	// fifo number only moves on a new frame
	AST_SEL_HOLD: assert property (
		!rx_valid |=> $stable(fifo_sel))
		else $error("fifo number moved");
	AST_B_HOLD: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_R_LAT: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_B_LAT: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write answer late");
	AST_AR_BLOCK: assert property (
		s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
		else $error("read taken while answering");
endmodule

bind can_filter_route_control can_filt_checker i_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .rx_id, .rx_valid, .fifo_wr, .fifo_sel, .fifo_id
);

// ### verif/can_node.sv
// other bus node: hands received frames to the filter block
// assumes it shares aclk with the block
`timescale 1ns/1ps
module can_node
	import can_filt_pkg::*;
(
	// clock
	input wire logic aclk,
	// frame toward the block
	output logic [can_filt_pkg::id_w-1:0] rx_id,
	output logic rx_valid
);
	initial begin
		rx_id = 29'h0;
		rx_valid = 1'h0;
	end
	// gap idles first; id inverted after so the stale value differs from the frame
	task automatic send(input logic [28:0] id, input int gap);
		repeat (gap) @(posedge aclk);
		@(posedge aclk);
		rx_id <= id;
		rx_valid <= 1'h1;
		@(posedge aclk);
		rx_id <= ~id;
		rx_valid <= 1'h0;
	endtask
endmodule

// ### verif/testbench.sv
// self-checking bench for the filter routing block
// assumes the node model and checker are compiled first
`timescale 1ns/1ps
module testbench;
	import can_filt_pkg::*;
	typedef struct {
		logic [31:0] w0, w1;
		logic [28:0] id;
		logic wr;
		logic [3:0] sel;
	} row_t;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic clk_en = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, fifo_sel;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, rx_valid, fifo_wr;
	logic [28:0] rx_id, fifo_id;
	int fail_count = 0, total_checks = 0, cyc = 0;
	// masks: full, none, low nibble, all but low nibble
	logic [31:0] masks [4] = '{32'h1fffffff, 32'h0, 32'hf, 32'h1ffffff0};
	// filter i identifier is 0x100+i
	row_t rows [9] = '{
		'{32'h85, 32'h0, 29'h100, 1'h1, 4'h5},
		'{32'h85, 32'h0, 29'h101, 1'h0, 4'h5},
		'{32'h05, 32'h0, 29'h100, 1'h0, 4'h5},
		'{32'haf00, 32'h0, 29'h1234, 1'h1, 4'hf},
		'{32'hc00000, 32'h0, 29'hff2, 1'h1, 4'h0},
		'{32'hc00000, 32'h0, 29'h103, 1'h0, 4'h0},
		'{32'he9000000, 32'h0, 29'h10c, 1'h1, 4'h9},
		'{32'h0, 32'h8c0000, 29'h106, 1'h1, 4'hc},
		'{32'ha7a3, 32'h0, 29'h55, 1'h1, 4'h3}};
	can_filter_route_control i_dut (
		.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_id, .rx_valid,
		.fifo_wr, .fifo_sel, .fifo_id);
	can_node i_node (.aclk, .rx_id, .rx_valid);
	always #2 aclk = ~aclk;
	// run is a few hundred cycles; ceiling cuts a hang
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	// response ready raised late so the slave must hold it
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rsp);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h1;
		@(posedge aclk);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rsp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic results();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(filter_ctrl_word_1_off, d, r);
		chk("word1_rst", d, ctrl_word_reset);
		rd(8'h80, d, r);
		chk("unmapped", r, resp_slverr);
		// masks only while still in configuration mode
		for (int i = 0; i < 4; i++)
			wr(mask_0_off + 8'(4 * i), masks[i], r);
		for (int i = 0; i < 8; i++)
			wr(filter_id_0_off + 8'(4 * i), 32'h100 + i, r);
		wr(8'h00, 32'h85, r);
		i_node.send(29'h100, 0);
		#1;
		chk("cfg_no_wr", fifo_wr, 32'h0);
		wr(mode_off, 32'h0, r);
		wr(mask_0_off, 32'h0, r);
		chk("mask_lock", r, resp_slverr);
		rd(mask_0_off, d, r);
		chk("mask_kept", d, masks[0]);
		foreach (rows[k]) begin
			wr(8'h00, rows[k].w0, r);
			wr(8'h04, rows[k].w1, r);
			rd(8'h00, d, r);
			chk("word0", d, rows[k].w0);
			rd(8'h04, d, r);
			chk("word1", d, rows[k].w1);
			i_node.send(rows[k].id, k % 2);
			#1;
			chk("fifo_wr", fifo_wr, rows[k].wr);
			if (rows[k].wr) begin
				chk("fifo_sel", fifo_sel, rows[k].sel);
				chk("fifo_id", fifo_id, rows[k].id);
			end
		end
		// both low filters saw the last frame
		rd(hit_status_off, d, r);
		chk("hits", d, 32'h3);
		// frozen clock enable: a frame must leave the outputs alone
		@(posedge aclk);
		clk_en <= 1'h0;
		i_node.send(29'h77, 0);
		#1;
		chk("frz_id", fifo_id, 32'h55);
		chk("frz_wr", fifo_wr, 32'h0);
		@(posedge aclk);
		clk_en <= 1'h1;
		// second reset clears the filled words
		@(posedge aclk);
		aresetn <= 1'h0;
		@(posedge aclk);
		aresetn <= 1'h1;
		rd(8'h00, d, r);
		chk("word0_rst", d, ctrl_word_reset);
		results();
	end
endmodule
